// ---- rtl/ctb_core.sv ----
// Counter/timer bank: two legacy timers and three up/down timers
`timescale 1ns/1ns
`include "ctb_map.svh"

// How it works
// - Gate off: count while run set; gate on: also need interrupt input high.
// - Counter select 1 counts count-pin falling edges; 0 uses chosen clock.
// - Timer 1 mode: 13-bit, 16-bit, 8-bit auto-reload, or inactive.
// - Timer 0 mode: 13-bit, 16-bit, 8-bit auto-reload, or two 8-bit timers.
// - Timer 1 clock select: 1 system clock, 0 prescaled; ignored as counter.
// - Timer 0 clock select: 1 system clock, 0 prescaled; ignored as counter.
// - Prescale field: divide by 12, 4, 48, or external clock by 8.
// - Unused clock-config bits 7-5 and 2 read zero, writes ignored.
// - Legacy counts are readable, writable low and high bytes, reset zero.
// - Timers 2-4 each hold a 16-bit count of low and high byte.
// - Upper counter select 0 uses internal clock, 1 counts pin falling edges.
// - Upper clock select: system clock, divided by 2, by 12, external by 8.
// - With decrement enable, direction pin high counts up, low counts down.
// - With decrement enable, direction pin only steers, never reloads.
// - Timers 2,3 give converter start triggers; timers 2-4 give output triggers.
// - Second serial port baud from timer 1 only; first selects timer 1-4.
// - 13-bit mode uses high byte and five low bits, flags wrap to zero.
// - Auto-reload: low byte counts, on wrap flags and reloads from high byte.
// - Split mode high byte runs on internal clock, timer 1 run, flags timer 1.
// - Setting run never clears counts; counting resumes from held value.
module ctb_core (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    input wire logic timer0_run,
    input wire logic timer1_run,
    input wire logic ext_irq0_input,
    input wire logic ext_irq1_input,
    input wire logic timer0_count_pin,
    input wire logic timer1_count_pin,
    input wire logic ext_osc_clk,
    input wire ctb_pkg::ctb_upcfg_s [2:0] upper_timer_cfg,
    input wire logic [2:0] upper_timer_count_pin,
    input wire logic [2:0] upper_timer_direction_pin,
    input wire logic [2:0] upper_timer_load,
    input wire logic [15:0] upper_timer_load_value,
    input wire logic [1:0] uart0_baud_select,
    output logic [2:0][15:0] upper_timer_count,
    output logic timer0_overflow,
    output logic timer1_overflow,
    output logic [2:0] upper_timer_overflow,
    output logic [1:0] adc_trigger,
    output logic [2:0] dac_trigger,
    output logic uart1_baud_tick,
    output logic uart0_baud_tick
);
    import ctb_pkg::*;

    localparam int NPIN = 11;
    localparam int P_T0 = 0;
    localparam int P_T1 = 1;
    localparam int P_I0 = 2;
    localparam int P_I1 = 3;
    localparam int P_OSC = 4;
    localparam int P_UC = 5;
    localparam int P_UD = 8;

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers; levels use the second stage, edges the second and third
    logic [NPIN-1:0] pin_raw, sync1, sync2, sync3;
    logic [NPIN-1:0] pin_fall;
    assign pin_raw = {upper_timer_direction_pin, upper_timer_count_pin, ext_osc_clk,
                      ext_irq1_input, ext_irq0_input, timer1_count_pin, timer0_count_pin};
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            sync1 <= '0;
            sync2 <= '0;
            sync3 <= '0;
        end else begin
            sync1 <= pin_raw;
            sync2 <= sync1;
            sync3 <= sync2;
        end
    end
    assign pin_fall = sync3 & ~sync2;

    ////////////////////////////////////////////////////////////////////////
    // Prescalers
    logic [5:0] div4, div12, div48, next_div4, next_div12, next_div48;
    logic [2:0] ext8, next_ext8;
    logic div2, next_div2;
    logic tick4, tick12, tick48, tick_ext8, osc_rise;
    assign tick4 = (div4 == `CTB_DIV_4_LAST);
    assign tick12 = (div12 == `CTB_DIV_12_LAST);
    assign tick48 = (div48 == `CTB_DIV_48_LAST);
    assign osc_rise = sync2[P_OSC] & ~sync3[P_OSC];
    assign tick_ext8 = osc_rise && (ext8 == `CTB_EXT_DIV_LAST);
    always_comb begin
        next_div4 = tick4 ? 6'h00 : div4 + 6'h01;
        next_div12 = tick12 ? 6'h00 : div12 + 6'h01;
        next_div48 = tick48 ? 6'h00 : div48 + 6'h01;
        next_ext8 = osc_rise ? ext8 + 3'h1 : ext8;
        next_div2 = ~div2;
    end
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            div4 <= 6'h00;
            div12 <= 6'h00;
            div48 <= 6'h00;
            ext8 <= 3'h0;
            div2 <= 1'b0;
        end else begin
            div4 <= next_div4;
            div12 <= next_div12;
            div48 <= next_div48;
            ext8 <= next_ext8;
            div2 <= next_div2;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers and legacy timers
    logic [7:0] mode_cfg, clock_cfg, tl0, th0, tl1, th1;
    logic [7:0] next_mode_cfg, next_clock_cfg, next_tl0, next_th0, next_tl1, next_th1;
    logic [7:0] next_rdata;
    logic next_ovf0, next_ovf1, next_baud1;
    logic pre_tick, en0, en1, inc0, inc1, inc_th0, split;
    logic [16:0] st0, st1;
    ctb_mode_e mode0, mode1;
    assign mode0 = ctb_mode_e'(mode_cfg[`CTB_POS_MODE0 +: 2]);
    assign mode1 = ctb_mode_e'(mode_cfg[`CTB_POS_MODE1 +: 2]);
    assign split = (mode0 == CTB_MODE_SPLIT);

    // One count step: {wrap, high, low}
    function automatic logic [16:0] ctb_step(input ctb_mode_e m, input logic [7:0] lo, input logic [7:0] hi);
        logic [16:0] r;
        r = {1'b0, hi, lo};
        case (m)
            CTB_MODE_13BIT: begin
                r[4:0] = lo[4:0] + 5'h01;
                if (lo[4:0] == 5'h1f) begin
                    r[15:8] = hi + 8'h01;
                    r[16] = (hi == 8'hff);
                end
            end
            CTB_MODE_16BIT: r = {1'b0, hi, lo} + 17'h00001;
            CTB_MODE_RELOAD: begin
                if (lo == 8'hff) begin
                    r[7:0] = hi;
                    r[16] = 1'b1;
                end else begin
                    r[7:0] = lo + 8'h01;
                end
            end
            default: begin
                r[7:0] = lo + 8'h01;
                r[16] = (lo == 8'hff);
            end
        endcase
        return r;
    endfunction : ctb_step

    always_comb begin
        case (clock_cfg[`CTB_POS_PRESCALE +: 2])
            2'h0: pre_tick = tick12;
            2'h1: pre_tick = tick4;
            2'h2: pre_tick = tick48;
            default: pre_tick = tick_ext8;
        endcase
        en0 = timer0_run && (!mode_cfg[`CTB_BIT_TIMER0_GATE_ENABLE] || sync2[P_I0]);
        inc0 = en0 && (mode_cfg[`CTB_BIT_CT0] ? pin_fall[P_T0] :
                       (clock_cfg[`CTB_BIT_T0_SYSTEM_CLOCK] || pre_tick));
        // In split mode timer 1 runs by its mode alone and takes no pin clock
        if (split) begin
            en1 = 1'b1;
            inc1 = (mode1 != CTB_MODE_SPLIT) && (clock_cfg[`CTB_BIT_T1_SYSTEM_CLOCK] || pre_tick);
        end else begin
            en1 = timer1_run && (!mode_cfg[`CTB_BIT_TIMER1_GATE_ENABLE] || sync2[P_I1]);
            inc1 = en1 && (mode1 != CTB_MODE_SPLIT) &&
                   (mode_cfg[`CTB_BIT_CT1] ? pin_fall[P_T1] :
                    (clock_cfg[`CTB_BIT_T1_SYSTEM_CLOCK] || pre_tick));
        end
        inc_th0 = split && timer1_run && (clock_cfg[`CTB_BIT_T0_SYSTEM_CLOCK] || pre_tick);
        st0 = ctb_step(mode0, tl0, th0);
        st1 = ctb_step(mode1, tl1, th1);
        next_tl0 = tl0;
        next_th0 = th0;
        next_tl1 = tl1;
        next_th1 = th1;
        next_ovf0 = 1'b0;
        next_ovf1 = 1'b0;
        next_baud1 = 1'b0;
        // Counts continue from whatever is held; run never clears them
        if (inc0) begin
            next_tl0 = st0[7:0];
            next_th0 = split ? th0 : st0[15:8];
            next_ovf0 = st0[16];
        end
        if (inc_th0) begin
            next_th0 = th0 + 8'h01;
            next_ovf1 = (th0 == 8'hff);
        end
        if (inc1) begin
            next_tl1 = st1[7:0];
            next_th1 = st1[15:8];
            next_baud1 = st1[16];
            if (!split) begin
                next_ovf1 = st1[16];
            end
        end
        next_mode_cfg = mode_cfg;
        next_clock_cfg = clock_cfg;
        // A write wins over a count step in the same cycle
        if (sfr_wr) begin
            case (sfr_addr)
                `CTB_ADDR_MODE_CFG: next_mode_cfg = sfr_wdata;
                `CTB_ADDR_T0_LOW: next_tl0 = sfr_wdata;
                `CTB_ADDR_T1_LOW: next_tl1 = sfr_wdata;
                `CTB_ADDR_T0_HIGH: next_th0 = sfr_wdata;
                `CTB_ADDR_T1_HIGH: next_th1 = sfr_wdata;
                `CTB_ADDR_CLOCK_CFG: next_clock_cfg = sfr_wdata & `CTB_CLOCK_CFG_MASK;
                default: next_mode_cfg = mode_cfg;
            endcase
        end
        case (sfr_addr)
            `CTB_ADDR_MODE_CFG: next_rdata = mode_cfg;
            `CTB_ADDR_T0_LOW: next_rdata = tl0;
            `CTB_ADDR_T1_LOW: next_rdata = tl1;
            `CTB_ADDR_T0_HIGH: next_rdata = th0;
            `CTB_ADDR_T1_HIGH: next_rdata = th1;
            `CTB_ADDR_CLOCK_CFG: next_rdata = clock_cfg;
            default: next_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            mode_cfg <= `CTB_RST_BYTE;
            clock_cfg <= `CTB_RST_BYTE;
            tl0 <= `CTB_RST_BYTE;
            th0 <= `CTB_RST_BYTE;
            tl1 <= `CTB_RST_BYTE;
            th1 <= `CTB_RST_BYTE;
            sfr_rdata <= 8'h00;
            timer0_overflow <= 1'b0;
            timer1_overflow <= 1'b0;
            uart1_baud_tick <= 1'b0;
        end else begin
            mode_cfg <= next_mode_cfg;
            clock_cfg <= next_clock_cfg;
            tl0 <= next_tl0;
            th0 <= next_th0;
            tl1 <= next_tl1;
            th1 <= next_th1;
            sfr_rdata <= next_rdata;
            timer0_overflow <= next_ovf0;
            timer1_overflow <= next_ovf1;
            uart1_baud_tick <= next_baud1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Timers 2-4
    logic [2:0] utick, next_uovf;
    logic [2:0][15:0] next_ucount;
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_upper
            logic clk_tick, up;
            always_comb begin
                case (upper_timer_cfg[g].upper_timer_clock_select)
                    CTB_UCLK_SYS: clk_tick = 1'b1;
                    CTB_UCLK_DIV2: clk_tick = div2;
                    CTB_UCLK_DIV12: clk_tick = tick12;
                    default: clk_tick = tick_ext8;
                endcase
                utick[g] = upper_timer_cfg[g].run && (upper_timer_cfg[g].upper_timer_counter_select ?
                           pin_fall[P_UC+g] : clk_tick);
                // Direction pin only steers; its edges are never used here
                up = !upper_timer_cfg[g].decrement_enable || sync2[P_UD+g];
                next_ucount[g] = upper_timer_count[g];
                next_uovf[g] = 1'b0;
                if (upper_timer_load[g]) begin
                    next_ucount[g] = upper_timer_load_value;
                end else if (utick[g]) begin
                    next_ucount[g] = up ? upper_timer_count[g] + 16'h0001 : upper_timer_count[g] - 16'h0001;
                    next_uovf[g] = up ? (upper_timer_count[g] == 16'hffff) : (upper_timer_count[g] == 16'h0000);
                end
            end
        end
    endgenerate

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            upper_timer_count <= '0;
            upper_timer_overflow <= 3'h0;
        end else begin
            upper_timer_count <= next_ucount;
            upper_timer_overflow <= next_uovf;
        end
    end

    assign adc_trigger = upper_timer_overflow[1:0];
    assign dac_trigger = upper_timer_overflow;
    always_comb begin
        case (uart0_baud_select)
            2'h0: uart0_baud_tick = uart1_baud_tick;
            2'h1: uart0_baud_tick = upper_timer_overflow[0];
            2'h2: uart0_baud_tick = upper_timer_overflow[1];
            default: uart0_baud_tick = upper_timer_overflow[2];
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    logic wr_t0, wr_t1;
    assign wr_t0 = sfr_wr && (sfr_addr == `CTB_ADDR_T0_LOW || sfr_addr == `CTB_ADDR_T0_HIGH);
    assign wr_t1 = sfr_wr && (sfr_addr == `CTB_ADDR_T1_LOW || sfr_addr == `CTB_ADDR_T1_HIGH);

    AST_GATE_HOLD: assert property (!en0 && !inc_th0 && !wr_t0 |=> {th0, tl0} == $past({th0, tl0}))
        else $error("Timer 0 moved while disabled");
    AST_PIN_COUNT: assert property (mode_cfg[`CTB_BIT_CT0] && mode0 == CTB_MODE_16BIT && en0 && pin_fall[P_T0]
        && !wr_t0 && !sfr_wr |=> {th0, tl0} == $past({th0, tl0}) + 16'h0001)
        else $error("Timer 0 missed a pin edge");
    AST_T1_IDLE: assert property (mode1 == CTB_MODE_SPLIT && !wr_t1 |=> {th1, tl1} == $past({th1, tl1}))
        else $error("Timer 1 counted while inactive");
    AST_WRAP13: assert property (inc0 && mode0 == CTB_MODE_13BIT && th0 == 8'hff && tl0[4:0] == 5'h1f
        |=> timer0_overflow)
        else $error("13-bit wrap not flagged");
    AST_RELOAD: assert property (inc0 && mode0 == CTB_MODE_RELOAD && tl0 == 8'hff && !wr_t0
        |=> tl0 == $past(th0) && th0 == $past(th0) && timer0_overflow)
        else $error("Auto-reload failed");
    AST_SPLIT_HIGH: assert property (inc_th0 && th0 == 8'hff && !wr_t0 |=> timer1_overflow && th0 == 8'h00)
        else $error("Split high byte wrap not flagged");
    AST_CLK_RSVD: assert property ((clock_cfg & ~`CTB_CLOCK_CFG_MASK) == 8'h00)
        else $error("Unused clock config bits set");
    AST_DOWN: assert property (utick[0] && upper_timer_cfg[0].decrement_enable && !sync2[P_UD] && !upper_timer_load[0]
        |=> upper_timer_count[0] == $past(upper_timer_count[0]) - 16'h0001)
        else $error("Timer 2 did not count down");
    AST_ONE_EDGE: assert property (pin_fall[P_T0] |-> $past(timer0_count_pin, 3)
        && !$past(timer0_count_pin, 2))
        else $error("Pin edge not from one pin fall");
    COV_RELOAD: cover property (inc0 && mode0 == CTB_MODE_RELOAD && tl0 == 8'hff);
    COV_SPLIT: cover property (inc_th0 && th0 == 8'hff);
    COV_UNDER: cover property (next_uovf[0] && upper_timer_cfg[0].decrement_enable);
endmodule : ctb_core

// ---- rtl/ctb_map.svh ----
// Register offsets, field positions, reset values and divider counts
`ifndef CTB_MAP_SVH
`define CTB_MAP_SVH
`define CTB_ADDR_MODE_CFG 8'h89
`define CTB_ADDR_T0_LOW 8'h8a
`define CTB_ADDR_T1_LOW 8'h8b
`define CTB_ADDR_T0_HIGH 8'h8c
`define CTB_ADDR_T1_HIGH 8'h8d
`define CTB_ADDR_CLOCK_CFG 8'h8e
`define CTB_RST_BYTE 8'h00
`define CTB_CLOCK_CFG_MASK 8'h1b
`define CTB_BIT_TIMER1_GATE_ENABLE 7
`define CTB_BIT_CT1 6
`define CTB_POS_MODE1 4
`define CTB_BIT_TIMER0_GATE_ENABLE 3
`define CTB_BIT_CT0 2
`define CTB_POS_MODE0 0
`define CTB_BIT_T1_SYSTEM_CLOCK 4
`define CTB_BIT_T0_SYSTEM_CLOCK 3
`define CTB_POS_PRESCALE 0
`define CTB_DIV_4_LAST 6'h03
`define CTB_DIV_12_LAST 6'h0b
`define CTB_DIV_48_LAST 6'h2f
`define CTB_EXT_DIV_LAST 3'h7
`endif

// ---- rtl/ctb_pkg.sv ----
// Types shared by the counter/timer bank
package ctb_pkg;
    typedef enum logic [1:0] {
        CTB_MODE_13BIT = 2'h0,
        CTB_MODE_16BIT = 2'h1,
        CTB_MODE_RELOAD = 2'h2,
        CTB_MODE_SPLIT = 2'h3
    } ctb_mode_e;

    typedef enum logic [1:0] {
        CTB_UCLK_SYS = 2'h0,
        CTB_UCLK_DIV2 = 2'h1,
        CTB_UCLK_DIV12 = 2'h2,
        CTB_UCLK_EXT8 = 2'h3
    } ctb_uclk_e;

    // Control of one of timers 2-4
    typedef struct packed {
        logic run;
        logic upper_timer_counter_select;
        ctb_uclk_e upper_timer_clock_select;
        logic decrement_enable;
    } ctb_upcfg_s;
endpackage : ctb_pkg

// ---- tb/counter_timer_bank_tb_top.sv ----
// Self-checking bench of the counter/timer bank
`timescale 1ns/1ns
`define CHK(nm, ex, gt) begin checks_done++; if ((gt) !== (ex)) begin err_total++; \
    $display("BAD %s exp %h got %h", nm, (ex), (gt)); end end
module counter_timer_bank_tb_top;
    import ctb_pkg::*;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic t0_run = 1'b0, t1_run = 1'b0, irq0 = 1'b0, irq1 = 1'b0, t0_pin = 1'b1, t1_pin = 1'b1, osc = 1'b0;
    ctb_upcfg_s [2:0] ucfg = '0;
    logic [2:0] upin = 3'h7, udir = 3'h0, uload = 3'h0, uov, dac;
    logic [15:0] ulv = 16'h0000;
    logic [1:0] usel = 2'h0, adc;
    logic [7:0] addr, wdata, rdata;
    logic wr_s, t0_ov, t1_ov, u1_tick, u0_tick;
    logic [2:0][15:0] ucnt;
    int err_total = 0, checks_done = 0, cyc = 0, ocnt = 0;
    int ovc [0:5] = '{default: 0};
    int pdv [4] = '{12, 4, 48, 48};
    int udv [4] = '{1, 2, 12, 48};
    ctb_cpu_model cpu (.clk_sys(clk_sys), .sfr_addr(addr), .sfr_wr(wr_s), .sfr_wdata(wdata), .sfr_rdata(rdata));
    ctb_core dut (.clk_sys(clk_sys), .reset(reset), .sfr_addr(addr), .sfr_wr(wr_s), .sfr_wdata(wdata),
        .sfr_rdata(rdata), .timer0_run(t0_run), .timer1_run(t1_run), .ext_irq0_input(irq0),
        .ext_irq1_input(irq1), .timer0_count_pin(t0_pin), .timer1_count_pin(t1_pin), .ext_osc_clk(osc),
        .upper_timer_cfg(ucfg), .upper_timer_count_pin(upin), .upper_timer_direction_pin(udir),
        .upper_timer_load(uload), .upper_timer_load_value(ulv), .uart0_baud_select(usel),
        .upper_timer_count(ucnt), .timer0_overflow(t0_ov), .timer1_overflow(t1_ov),
        .upper_timer_overflow(uov), .adc_trigger(adc), .dac_trigger(dac), .uart1_baud_tick(u1_tick),
        .uart0_baud_tick(u0_tick));
    always #10 clk_sys = ~clk_sys;
    // Oscillator slower than the system clock: rising edge every 6 cycles
    always @(posedge clk_sys) begin
        ocnt <= (ocnt == 2) ? 0 : ocnt + 1;
        if (ocnt == 2) osc <= ~osc;
        usel <= 2'($urandom);
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            err_total++;
            end_sim();
        end
    end
    // Pulse counters; case equality keeps an unknown from counting
    logic [5:0] pulses;
    assign pulses = {u1_tick, uov, t1_ov, t0_ov};
    always @(posedge clk_sys) begin
        for (int k = 0; k < 6; k++) if (pulses[k] === 1'b1) ovc[k]++;
    end
    always @(negedge clk_sys) if (!reset) begin
        `CHK("dac_trigger", uov, dac)
        `CHK("adc_trigger", uov[1:0], adc)
        `CHK("uart0_baud_tick", (usel != 2'h0) ? uov[usel - 2'h1] : u1_tick, u0_tick)
    end
    ////////////////////////////////////////////////////////////
    function automatic logic [15:0] lg_exp(input int m, input logic [15:0] v, input int n, inout int ov);
        logic [12:0] c;
        for (int k = 0; k < n; k++) begin
            case (m)
                0: begin c = {v[15:8], v[4:0]} + 13'h1; v[15:8] = c[12:5]; v[4:0] = c[4:0]; ov += (c == 13'h0); end
                1: begin v = v + 16'h1; ov += (v == 16'h0); end
                2: begin v[7:0] = v[7:0] + 8'h1; if (v[7:0] == 8'h0) begin v[7:0] = v[15:8]; ov++; end end
                3: begin v[7:0] = v[7:0] + 8'h1; ov += (v[7:0] == 8'h0); end
                default: ;
            endcase
        end
        return v;
    endfunction : lg_exp
    task automatic set_run(input int w, input logic v);
        case (w)
            0: t0_run <= v;
            1: t1_run <= v;
            default: ucfg[w - 2].run <= v;
        endcase
    endtask : set_run
    task automatic pulse(input int w);
        for (int k = 0; k < 2; k++) begin
            case (w)
                0: t0_pin <= 1'(k);
                1: t1_pin <= 1'(k);
                default: upin[w - 2] <= 1'(k);
            endcase
            repeat (4) @(posedge clk_sys);
        end
    endtask : pulse
    task automatic run_for(input int w, input int n);
        @(posedge clk_sys);
        set_run(w, 1'b1);
        repeat (n) @(posedge clk_sys);
        set_run(w, 1'b0);
    endtask : run_for
    task automatic rd16(input int t, output logic [15:0] v);
        cpu.rd(8'(8'h8a + t), v[7:0]);
        cpu.rd(8'(8'h8c + t), v[15:8]);
    endtask : rd16
    task automatic wr16(input int t, input logic [15:0] v);
        cpu.wr(8'(8'h8a + t), v[7:0]);
        cpu.wr(8'(8'h8c + t), v[15:8]);
    endtask : wr16
    // Load waits out the pin synchronisers before any run window
    task automatic setup(input int i, input logic [4:0] cf, input logic dr, input logic [15:0] v);
        @(posedge clk_sys);
        ucfg[i] <= cf;
        udir[i] <= dr;
        uload[i] <= 1'b1;
        ulv <= v;
        @(posedge clk_sys);
        uload[i] <= 1'b0;
        repeat (5) @(posedge clk_sys);
        @(negedge clk_sys);
        `CHK("upper_load", v, ucnt[i])
    endtask : setup
    task automatic end_sim();
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : end_sim
    ////////////////////////////////////////////////////////////
    initial begin
        logic [7:0] d;
        logic [15:0] lv;
        int n, ov;
        logic dn, dr, up;
        logic [15:0] lx;
        int ub;
        void'($urandom(39));
        repeat (12) @(posedge clk_sys);
        reset <= 1'b0;
        for (int a = 8'h88; a < 8'h8f; a++) begin
            cpu.rd(8'(a), d);
            `CHK("reset_value", 8'h00, d)
        end
        cpu.wr(8'h8e, 8'hff);
        cpu.rd(8'h8e, d);
        `CHK("clock_cfg", 8'h1b, d)
        for (int a = 8'h8d; a > 8'h88; a--) begin
            lv = 16'($urandom);
            cpu.wr(8'(a), lv[7:0]);
            cpu.rd(8'(a), d);
            `CHK("readback", lv[7:0], d)
        end
        cpu.wr(8'h8e, 8'h18);
        for (int t = 0; t < 2; t++) begin
            for (int m = 0; m < 4; m++) begin
                cpu.wr(8'h89, t ? 8'(m << 4) : 8'(8'h30 | m));
                lv = {(m == 2) ? 8'($urandom) : 8'hff, 8'hf0 | 8'($urandom % 16)};
                n = 20 + $urandom % 20;
                wr16(t, lv);
                ov = ovc[t];
                ub = ovc[5] - ovc[1];
                run_for(t, n);
                lx = lg_exp((t == 1 && m == 3) ? 4 : m, lv, n, ov);
                rd16(t, lv);
                `CHK("legacy_count", lx, lv)
                `CHK("legacy_overflows", ov, ovc[t])
                `CHK("uart1_baud", ub, ovc[5] - ovc[1])
            end
        end
        cpu.wr(8'h89, 8'h33);
        lv = {8'h00, 8'hf0 | 8'($urandom % 16)};
        cpu.wr(8'h8c, lv[7:0]);
        ov = ovc[1];
        run_for(1, 30);
        lv = lg_exp(3, lv, 30, ov);
        cpu.rd(8'h8c, d);
        `CHK("split_high", lv[7:0], d)
        `CHK("split_flags", ov, ovc[1])
        cpu.wr(8'h89, 8'h39);
        wr16(0, 16'h0000);
        run_for(0, 10);
        irq0 <= 1'b1;
        repeat (5) @(posedge clk_sys);
        run_for(0, 10);
        irq0 <= 1'b0;
        rd16(0, lv);
        `CHK("gated_count", 16'h000a, lv)
        for (int t = 0; t < 2; t++) begin
            cpu.wr(8'h89, t ? 8'h50 : 8'h35);
            wr16(t, 16'h0000);
            @(posedge clk_sys);
            set_run(t, 1'b1);
            n = 3 + $urandom % 5;
            repeat (n) pulse(t);
            repeat (5) @(posedge clk_sys);
            set_run(t, 1'b0);
            rd16(t, lv);
            `CHK("pin_count", 16'(n), lv)
            for (int s = 0; s < 4; s++) begin
                cpu.wr(8'h89, t ? 8'h10 : 8'h31);
                cpu.wr(8'h8e, 8'(s));
                wr16(t, 16'h0000);
                run_for(t, 384);
                rd16(t, lv);
                `CHK("prescaled_count", 16'(384 / pdv[s]), lv)
            end
        end
        for (int i = 0; i < 3; i++) begin
            for (int c = 0; c < 4; c++) begin
                lv = (($urandom % 2) ? 16'hfff8 : 16'h0000) + 16'($urandom % 16);
                dn = 1'($urandom);
                dr = 1'($urandom);
                up = !dn || dr;
                setup(i, {2'b00, 2'(c), dn}, dr, lv);
                ov = ovc[i + 2] + (up ? (lv > 16'hffef) : (lv < 16'h0010));
                run_for(i + 2, 16 * udv[c]);
                repeat (2) @(posedge clk_sys);
                @(negedge clk_sys);
                `CHK("upper_count", up ? lv + 16'h0010 : lv - 16'h0010, ucnt[i])
                `CHK("upper_overflows", ov, ovc[i + 2])
            end
            // Direction edge while decrementing must not reload the count
            setup(i, 5'b01001, 1'b1, 16'h0002);
            udir[i] <= 1'b0;
            repeat (5) @(posedge clk_sys);
            ov = ovc[i + 2] + 1;
            set_run(i + 2, 1'b1);
            repeat (5) pulse(i + 2);
            repeat (5) @(posedge clk_sys);
            set_run(i + 2, 1'b0);
            repeat (2) @(posedge clk_sys);
            @(negedge clk_sys);
            `CHK("upper_pin_count", 16'hfffd, ucnt[i])
            `CHK("upper_underflow", ov, ovc[i + 2])
        end
        end_sim();
    end
endmodule : counter_timer_bank_tb_top

// ---- tb/ctb_cpu_model.sv ----
// CPU model driving the special function register bus
`timescale 1ns/1ns
module ctb_cpu_model (
    input wire logic clk_sys,
    output logic [7:0] sfr_addr,
    output logic sfr_wr,
    output logic [7:0] sfr_wdata,
    input wire logic [7:0] sfr_rdata
);
    initial begin
        sfr_addr = 8'h00;
        sfr_wr = 1'b0;
        sfr_wdata = 8'h00;
    end
    ////////////////////////////////////////////////////////////
    // One-cycle strobe per write
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        sfr_addr <= a;
        sfr_wdata <= d;
        sfr_wr <= 1'b1;
        @(posedge clk_sys);
        sfr_wr <= 1'b0;
    endtask : wr
    // Data is registered, so look a full cycle after the address lands
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        sfr_addr <= a;
        @(posedge clk_sys);
        @(negedge clk_sys);
        d = sfr_rdata;
    endtask : rd
endmodule : ctb_cpu_model
